// ===== verilog/sensor_mode_regs.svh
// Timing counts, sync codes and reset values of the sensor mode and video output block.
`ifndef SENSOR_MODE_REGS_SVH
`define SENSOR_MODE_REGS_SVH
`define PIX_W          10
`define SYNC_HDR       10'h3ff
`define CODE_FRAME     10'h2ac
`define CODE_LINE      10'h200
`define CODE_BLANK     10'h2d8
`define SYNC_WORDS     2
`define ACTIVE_PIX     644
`define ACTIVE_LINES   484
`define DEFAULT_BLANK  16'h0010
`define SYS_CLK_NS     40
`define LINK_BIT_NS    320
`define BIT_CYCLES     ((`LINK_BIT_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define LEAK_SHIFT     2
`define STAT_W         32
`define DARK_RESET     10'h000
`endif

// ===== verilog/sensor_mode_pkg.sv
// Types shared by the sensor mode and video output block.
package sensor_mode_pkg;
  typedef enum {
    MODE_STANDBY,
    MODE_SLEEP,
    MODE_SLEEP_PEND,
    MODE_CLK_ACTIVE,
    MODE_IDLE,
    MODE_VIDEO
  } mode_e;

  typedef enum logic [1:0] {
    CMD_SLEEP,
    CMD_CLK_ACTIVE,
    CMD_IDLE,
    CMD_VIDEO
  } cmd_e;

  typedef struct packed {
    logic pad_clk;
    logic pll;
    logic analog;
    logic digital;
    logic array_reset;
  } power_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] sum;
  } stat_s;
endpackage

// ===== verilog/word_buffer.sv
// Small valid/ready word buffer that sits between the word generator and the serializer.
`timescale 1ns/100ps
`default_nettype none
module word_buffer #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_n,
  input  wire logic             i_clear,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_r;
  logic [PW-1:0]    rd_r;
  logic [PW:0]      count_r;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count_r != (PW+1)'(DEPTH));
  assign o_out_valid = (count_r != '0);
  assign o_out_data  = mem_r[rd_r];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_r[wr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_r    <= '0;
      rd_r    <= '0;
      count_r <= '0;
    end else if (i_clear) begin
      wr_r    <= '0;
      rd_r    <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == PW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == PW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ===== verilog/sensor_mode_video.sv
// Mode sequencing, video word generation and serial video output of the image sensor.
`timescale 1ns/100ps
`default_nettype none
`include "sensor_mode_regs.svh"
module sensor_mode_video import sensor_mode_pkg::*; #(
  parameter int          ACTIVE_PIX    = `ACTIVE_PIX,
  parameter int          ACTIVE_LINES  = `ACTIVE_LINES,
  parameter logic [15:0] DEFAULT_BLANK = `DEFAULT_BLANK,
  parameter int          BIT_CYCLES    = `BIT_CYCLES,
  parameter int          BUF_DEPTH     = 2
) (
  input  wire logic                i_clk_sys,
  input  wire logic                i_rst_n,
  input  wire logic                i_standby_request_n,
  input  wire logic                i_mode_cmd_valid,
  input  wire cmd_e                i_mode_cmd,
  input  wire logic                i_blank_lines_load,
  input  wire logic [15:0]         i_blank_lines,
  input  wire logic [`PIX_W-1:0]   i_pixel_data,
  input  wire logic [`PIX_W-1:0]   i_dark_level,
  output logic                     o_pixel_take,
  output logic                     o_control_bus_enable,
  output power_s                   o_power,
  output stat_s                    o_stat,
  output logic [`PIX_W-1:0]        o_dark_offset,
  output logic                     o_qualifying_clock_pos,
  output logic                     o_qualifying_clock_neg,
  output logic                     o_serial_video_data_pos,
  output logic                     o_serial_video_data_neg
);
  localparam logic [9:0] LAST_WORD = 10'(ACTIVE_PIX + `SYNC_WORDS - 1);
  localparam logic [7:0] BIT_LAST  = 8'(BIT_CYCLES - 1);
  localparam logic [7:0] BIT_HALF  = 8'(BIT_CYCLES / 2);

  // The standby pin is asynchronous; the first stage feeds only the second.
  logic pdn_s1_r;
  logic pdn_s2_r;
  logic pdn_s3_r;
  logic standby_r;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pdn_s1_r <= 1'b0;
      pdn_s2_r <= 1'b0;
      pdn_s3_r <= 1'b0;
    end else begin
      pdn_s1_r <= i_standby_request_n;
      pdn_s2_r <= pdn_s1_r;
      pdn_s3_r <= pdn_s2_r;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      standby_r <= 1'b1;
    end else if (pdn_s2_r == pdn_s3_r) begin
      standby_r <= ~pdn_s3_r;
    end
  end

  mode_e state_r;
  cmd_e  target_r;
  logic  frame_done_r;
  logic  drained;
  logic  frame_end;
  logic  ser_busy;
  logic  buf_out_valid;
  logic  bit_en;

  // Commands only arrive from the control bus, which is shut in standby.
  assign o_control_bus_enable = (state_r != MODE_STANDBY);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      target_r <= CMD_SLEEP;
    end else if (state_r == MODE_STANDBY) begin
      target_r <= CMD_SLEEP;
    end else if (i_mode_cmd_valid) begin
      target_r <= i_mode_cmd;
    end
  end

  // Sleep waits for the bit boundary after the last word, so its final bit stands a full period.
  assign drained = frame_done_r && !buf_out_valid && !ser_busy && bit_en;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= MODE_STANDBY;
    end else if (standby_r) begin
      state_r <= MODE_STANDBY;
    end else begin
      case (state_r)
        MODE_STANDBY: begin
          state_r <= MODE_SLEEP;
        end
        MODE_SLEEP: begin
          if (target_r != CMD_SLEEP) begin
            state_r <= MODE_CLK_ACTIVE;
          end
        end
        MODE_CLK_ACTIVE: begin
          if (target_r == CMD_SLEEP) begin
            state_r <= MODE_SLEEP;
          end else if (target_r != CMD_CLK_ACTIVE) begin
            state_r <= MODE_IDLE;
          end
        end
        MODE_IDLE: begin
          if (target_r == CMD_SLEEP) begin
            state_r <= MODE_SLEEP;
          end else if (target_r == CMD_CLK_ACTIVE) begin
            state_r <= MODE_CLK_ACTIVE;
          end else if (target_r == CMD_VIDEO) begin
            state_r <= MODE_VIDEO;
          end
        end
        MODE_VIDEO: begin
          if (target_r != CMD_VIDEO) begin
            state_r <= MODE_SLEEP_PEND;
          end
        end
        MODE_SLEEP_PEND: begin
          if (drained) begin
            state_r <= MODE_SLEEP;
          end
        end
        default: begin
          state_r <= MODE_STANDBY;
        end
      endcase
    end
  end

  // A stepped-down request from video always passes through sleep before rising again.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_power <= '0;
    end else begin
      o_power.pad_clk     <= (state_r != MODE_STANDBY);
      o_power.pll         <= (state_r == MODE_CLK_ACTIVE) || (state_r == MODE_IDLE) ||
                             (state_r == MODE_VIDEO) || (state_r == MODE_SLEEP_PEND);
      o_power.analog      <= (state_r == MODE_IDLE) || (state_r == MODE_VIDEO) ||
                             (state_r == MODE_SLEEP_PEND);
      o_power.digital     <= (state_r == MODE_VIDEO) || (state_r == MODE_SLEEP_PEND);
      o_power.array_reset <= (state_r != MODE_VIDEO) && (state_r != MODE_SLEEP_PEND);
    end
  end

  // Word generator: two sync words then the pixels of each active line, or zeros on a blank line.
  logic              gen_run;
  logic              gen_valid;
  logic              buf_in_ready;
  logic              push;
  logic [9:0]        word_cnt_r;
  logic [15:0]       line_cnt_r;
  logic [15:0]       blank_r;
  logic [15:0]       frame_lines_m1;
  logic [`PIX_W-1:0] word;
  logic [`PIX_W-1:0] corrected;
  logic              active_line;
  logic              frame_start;

  assign gen_run        = (state_r == MODE_VIDEO) || ((state_r == MODE_SLEEP_PEND) && !frame_done_r);
  assign gen_valid      = gen_run;
  assign push           = gen_valid && buf_in_ready;
  assign frame_lines_m1 = 16'(ACTIVE_LINES - 1) + blank_r;
  assign active_line    = (line_cnt_r < 16'(ACTIVE_LINES));
  assign frame_start    = push && (word_cnt_r == '0) && (line_cnt_r == '0);
  assign frame_end      = push && (word_cnt_r == LAST_WORD) && (line_cnt_r == frame_lines_m1);
  assign o_pixel_take   = push && active_line && (word_cnt_r >= 10'(`SYNC_WORDS));

  always_comb begin
    if (word_cnt_r == '0) begin
      word = `SYNC_HDR;
    end else if (word_cnt_r == 10'd1) begin
      if (line_cnt_r == '0) begin
        word = `CODE_FRAME;
      end else if (active_line) begin
        word = `CODE_LINE;
      end else begin
        word = `CODE_BLANK;
      end
    end else if (active_line) begin
      word = corrected;
    end else begin
      word = '0;
    end
  end

  // Blank line count is only picked up between frames so that one frame never changes length.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      blank_r <= DEFAULT_BLANK;
    end else if (i_blank_lines_load && !gen_run) begin
      blank_r <= i_blank_lines;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      word_cnt_r <= '0;
      line_cnt_r <= '0;
    end else if (!gen_run) begin
      word_cnt_r <= '0;
      line_cnt_r <= '0;
    end else if (push) begin
      if (word_cnt_r == LAST_WORD) begin
        word_cnt_r <= '0;
        line_cnt_r <= (line_cnt_r == frame_lines_m1) ? '0 : line_cnt_r + 16'd1;
      end else begin
        word_cnt_r <= word_cnt_r + 10'd1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame_done_r <= 1'b0;
    end else if (state_r != MODE_SLEEP_PEND) begin
      frame_done_r <= 1'b0;
    end else if (frame_end) begin
      frame_done_r <= 1'b1;
    end
  end

  // Dark offset: taken whole on the first frame, then damped to avoid flicker.
  logic               first_r;
  logic signed [11:0] dark_diff;

  assign dark_diff = $signed({2'b00, i_dark_level}) - $signed({2'b00, o_dark_offset});
  assign corrected = (i_pixel_data > o_dark_offset) ? i_pixel_data - o_dark_offset : '0;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      first_r       <= 1'b1;
      o_dark_offset <= `DARK_RESET;
    end else if (!gen_run) begin
      first_r <= (state_r != MODE_SLEEP_PEND) ? 1'b1 : first_r;
    end else if (frame_start) begin
      first_r <= 1'b0;
      if (first_r) begin
        o_dark_offset <= i_dark_level;
      end else begin
        o_dark_offset <= `PIX_W'($signed({2'b00, o_dark_offset}) + (dark_diff >>> `LEAK_SHIFT));
      end
    end
  end

  // Frame statistics: sum of corrected pixels, published at each frame end; with zero blank lines the last pixel is left out.
  logic [`STAT_W-1:0] sum_r;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sum_r  <= '0;
      o_stat <= '0;
    end else begin
      o_stat.valid <= frame_end;
      if (frame_end) begin
        o_stat.sum <= sum_r;
        sum_r      <= '0;
      end else if (o_pixel_take) begin
        sum_r <= sum_r + `STAT_W'(corrected);
      end
    end
  end

  // Serializer: one bit per bit period, most significant bit first.
  logic              pop;
  logic [`PIX_W-1:0] buf_out_data;
  logic [7:0]        div_cnt_r;
  logic [3:0]        bit_cnt_r;
  logic [`PIX_W-1:0] sh_r;
  logic              streaming;

  assign bit_en    = (div_cnt_r == BIT_LAST);
  assign streaming = (state_r == MODE_VIDEO) || (state_r == MODE_SLEEP_PEND);
  assign ser_busy  = (bit_cnt_r != '0);
  assign pop       = bit_en && streaming && !ser_busy && buf_out_valid;

  word_buffer #(
    .WIDTH (`PIX_W),
    .DEPTH (BUF_DEPTH)
  ) u_word_buffer (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (i_rst_n),
    .i_clear     (!streaming),
    .i_in_valid  (gen_valid),
    .i_in_data   (word),
    .o_in_ready  (buf_in_ready),
    .o_out_valid (buf_out_valid),
    .o_out_data  (buf_out_data),
    .i_out_ready (pop)
  );

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_cnt_r <= '0;
    end else if (!o_power.pll) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= bit_en ? '0 : div_cnt_r + 8'd1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bit_cnt_r <= '0;
      sh_r      <= '1;
    end else if (!streaming) begin
      bit_cnt_r <= '0;
      sh_r      <= '1;
    end else if (pop) begin
      bit_cnt_r <= 4'(`PIX_W - 1);
      sh_r      <= buf_out_data;
    end else if (bit_en && ser_busy) begin
      bit_cnt_r <= bit_cnt_r - 4'd1;
      sh_r      <= {sh_r[`PIX_W-2:0], 1'b1};
    end else if (bit_en) begin
      sh_r <= '1;
    end
  end

  // Both pairs are always driven by this end; a stopped pair rests at a fixed level.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_qualifying_clock_pos  <= 1'b0;
      o_qualifying_clock_neg  <= 1'b0;
      o_serial_video_data_pos <= 1'b1;
      o_serial_video_data_neg <= 1'b0;
    end else begin
      o_qualifying_clock_pos  <= o_power.pll && (div_cnt_r >= BIT_HALF);
      o_qualifying_clock_neg  <= o_power.pll && (div_cnt_r < BIT_HALF);
      o_serial_video_data_pos <= !streaming || sh_r[`PIX_W-1];
      o_serial_video_data_neg <= streaming && !sh_r[`PIX_W-1];
    end
  end

  sequence s_pend_open;
    (state_r == MODE_SLEEP_PEND) && !frame_done_r;
  endsequence

  sequence s_sleep_enter;
    $rose(state_r == MODE_SLEEP);
  endsequence

  property p_standby_hold;
    @(posedge i_clk_sys) disable iff (!i_rst_n) standby_r |=> (state_r == MODE_STANDBY);
  endproperty
  a_standby_hold: assert property (p_standby_hold) else $error("standby not held");

  property p_standby_power;
    @(posedge i_clk_sys) disable iff (!i_rst_n) (state_r == MODE_STANDBY) ##1 (state_r == MODE_STANDBY)
      |-> (o_power == '0 || o_power == 5'b00001) && !o_control_bus_enable;
  endproperty
  a_standby_power: assert property (p_standby_power) else $error("standby blocks not off");

  property p_sleep_waits;
    @(posedge i_clk_sys) disable iff (!i_rst_n) s_pend_open |=> (state_r != MODE_SLEEP);
  endproperty
  a_sleep_waits: assert property (p_sleep_waits) else $error("sleep before frame end");

  property p_sleep_data_high;
    @(posedge i_clk_sys) disable iff (!i_rst_n) s_sleep_enter |=> o_serial_video_data_pos && !o_power.pll;
  endproperty
  a_sleep_data_high: assert property (p_sleep_data_high) else $error("sleep data or pll wrong");

  property p_sleep_timing_reset;
    @(posedge i_clk_sys) disable iff (!i_rst_n) s_sleep_enter |-> (word_cnt_r == '0) && (line_cnt_r == '0);
  endproperty
  a_sleep_timing_reset: assert property (p_sleep_timing_reset) else $error("timing not reset");

  property p_clk_active;
    @(posedge i_clk_sys) disable iff (!i_rst_n) (state_r == MODE_CLK_ACTIVE) [*2]
      |-> o_power.pll && !o_power.analog && !o_power.digital && o_serial_video_data_pos;
  endproperty
  a_clk_active: assert property (p_clk_active) else $error("clock-active state wrong");

  property p_idle;
    @(posedge i_clk_sys) disable iff (!i_rst_n) (state_r == MODE_IDLE) [*2]
      |-> o_power.analog && o_power.array_reset && o_serial_video_data_pos;
  endproperty
  a_idle: assert property (p_idle) else $error("idle state wrong");

  property p_sync_header;
    @(posedge i_clk_sys) disable iff (!i_rst_n) frame_start |-> (word == `SYNC_HDR) ##1 (word == `CODE_FRAME);
  endproperty
  a_sync_header: assert property (p_sync_header) else $error("frame sync missing");

  property p_dark_first;
    @(posedge i_clk_sys) disable iff (!i_rst_n) frame_start && first_r |=> (o_dark_offset == $past(i_dark_level));
  endproperty
  a_dark_first: assert property (p_dark_first) else $error("first dark not taken");

  property p_stat;
    @(posedge i_clk_sys) disable iff (!i_rst_n) frame_end |=> o_stat.valid ##1 !o_stat.valid;
  endproperty
  a_stat: assert property (p_stat) else $error("statistics not published");

  property p_qclk_period;
    @(posedge i_clk_sys) disable iff (!i_rst_n) $rose(o_qualifying_clock_pos) && o_power.pll ##1 o_power.pll [*7]
      |=> $rose(o_qualifying_clock_pos) or !o_power.pll;
  endproperty
  a_qclk_period: assert property (p_qclk_period) else $error("qualifying clock period wrong");
endmodule
`default_nettype wire

// ===== verif/coproc_link_model.sv
// Companion coprocessor receiver that turns the serial video link back into words.
`timescale 1ns/100ps
`default_nettype none
`include "sensor_mode_regs.svh"
module coproc_link_model (
  input  wire logic i_clear,
  input  wire logic i_qclk_pos,
  input  wire logic i_qclk_neg,
  input  wire logic i_data_pos,
  input  wire logic i_data_neg
);
  logic [19:0]       win;
  logic              locked;
  int                nbit;
  int                bad;
  logic [`PIX_W-1:0] words[$];
  initial begin
    win = 20'h0_0000;
    locked = 1'b0;
    nbit = 0;
    bad = 0;
  end
  always @(posedge i_clear) begin
    locked = 1'b0;
    words.delete();
  end
  // Bits are taken mid-bit on the rising qualifying edge, most significant bit first.
  always @(posedge i_qclk_pos) begin
    // Both halves of the clock pair switch on one edge, so the pair is judged once both have settled.
    #5;
    if (i_data_neg === i_data_pos || i_qclk_neg !== 1'b0) begin
      bad++;
    end
    win = {win[18:0], i_data_pos};
    nbit++;
    // Idle lines are all ones, so locking needs the header and the frame code together.
    if (!locked && win == {`SYNC_HDR, `CODE_FRAME}) begin
      locked = 1'b1;
      nbit = 0;
      words.push_back(win[19:10]);
      words.push_back(win[9:0]);
    end else if (locked && nbit == 10) begin
      nbit = 0;
      words.push_back(win[9:0]);
    end
  end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking testbench of the sensor mode and video output block.
`timescale 1ns/100ps
`default_nettype none
`include "sensor_mode_regs.svh"
module tb_top import sensor_mode_pkg::*;;
  localparam int PIX = 4;
  localparam int LINES = 2;
  localparam int FW = (PIX + 2) * (LINES + 1);
  logic              clk, rst_n, stby_n, cmd_valid, blank_load, clr;
  cmd_e              mode_cmd;
  logic [15:0]       blank;
  logic [`PIX_W-1:0] pix, dark;
  int                failures, tests_run, cyc, a, b, c, takes;
  coproc_link_model m (.i_clear(clr), .i_qclk_pos(uut.o_qualifying_clock_pos),
    .i_qclk_neg(uut.o_qualifying_clock_neg), .i_data_pos(uut.o_serial_video_data_pos),
    .i_data_neg(uut.o_serial_video_data_neg));
  sensor_mode_video #(.ACTIVE_PIX(PIX), .ACTIVE_LINES(LINES), .DEFAULT_BLANK(16'h0001)) uut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_standby_request_n(stby_n), .i_mode_cmd_valid(cmd_valid),
    .i_mode_cmd(mode_cmd), .i_blank_lines_load(blank_load), .i_blank_lines(blank),
    .i_pixel_data(pix), .i_dark_level(dark), .o_pixel_take(), .o_control_bus_enable(),
    .o_power(), .o_stat(), .o_dark_offset(), .o_qualifying_clock_pos(), .o_qualifying_clock_neg(),
    .o_serial_video_data_pos(), .o_serial_video_data_neg());
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic send(input cmd_e c_in);
    @(negedge clk);
    mode_cmd = c_in;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
  task automatic wait_words(input int n);
    int k;
    k = 0;
    while (m.words.size() < n && k < 8000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 8000) begin
      failures++;
    end
  endtask
  task automatic wait_stat();
    int k;
    k = 0;
    while (uut.o_stat.valid !== 1'b1 && k < 4000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 4000) begin
      failures++;
    end
  endtask
  // Compares one frame in the model's queue, starting at word index first.
  task automatic chk_frame(input int first, input int blk, input logic [`PIX_W-1:0] off);
    int i;
    logic [`PIX_W-1:0] e;
    i = first;
    for (int l = 0; l < LINES + blk; l++) begin
      for (int p = 0; p < PIX + 2; p++) begin
        e = (p == 0) ? `SYNC_HDR : (p == 1) ? ((l == 0) ? `CODE_FRAME : (l < LINES) ? `CODE_LINE : `CODE_BLANK)
          : (l < LINES) ? pix - off : 10'h000;
        check("video_word", {22'h00_0000, m.words[i]}, {22'h00_0000, e});
        i++;
      end
    end
  endtask
  task automatic t_standby();
    check("power_standby", {27'h000_0000, uut.o_power}, 32'h0000_0001);
    check("data_idle", {30'h0, uut.o_serial_video_data_pos, uut.o_serial_video_data_neg}, 32'h2);
    send(CMD_VIDEO);
    repeat (10) @(negedge clk);
    check("bus_en_standby", {31'h0, uut.o_control_bus_enable}, 32'h0);
    check("cmd_refused", {31'h0, uut.o_power.pll}, 32'h0);
    stby_n = 1'b1;
    repeat (8) @(negedge clk);
    check("bus_en_sleep", {31'h0, uut.o_control_bus_enable}, 32'h1);
    check("sleep_power", {29'h0, uut.o_power.pad_clk, uut.o_power.pll, uut.o_power.analog}, 32'h4);
    $display("t_standby done");
  endtask
  task automatic t_modes();
    send(CMD_CLK_ACTIVE);
    repeat (4) @(negedge clk);
    check("clk_active_power", {30'h0, uut.o_power.pll, uut.o_power.digital}, 32'h2);
    a = m.nbit;
    repeat (16) @(negedge clk);
    check("qclk_runs", m.nbit - a, 2);
    check("clk_active_data", {31'h0, uut.o_serial_video_data_pos}, 32'h1);
    send(CMD_IDLE);
    repeat (4) @(negedge clk);
    check("idle_power", {29'h0, uut.o_power.analog, uut.o_power.array_reset, uut.o_power.digital}, 32'h6);
    check("idle_data", {31'h0, uut.o_serial_video_data_pos}, 32'h1);
    send(CMD_CLK_ACTIVE);
    repeat (4) @(negedge clk);
    check("idle_to_clk_active", {30'h0, uut.o_power.pll, uut.o_power.analog}, 32'h2);
    send(CMD_IDLE);
    repeat (4) @(negedge clk);
    $display("t_modes done");
  endtask
  task automatic t_video();
    send(CMD_VIDEO);
    wait_words(PIX + 2);
    dark = 10'h080;
    wait_stat();
    check("pixel_takes", takes, PIX * LINES);
    check("stat_sum1", uut.o_stat.sum, (32'h0000_00c0 - 32'h0000_0040) * PIX * LINES);
    check("offset1", {22'h0, uut.o_dark_offset}, 32'h0000_0040);
    @(negedge clk);
    wait_stat();
    check("offset2", {22'h0, uut.o_dark_offset}, 32'h0000_0050);
    check("stat_sum2", uut.o_stat.sum, 32'h0000_0070 * PIX * LINES);
    wait_words(2 * FW);
    chk_frame(0, 1, 10'h040);
    chk_frame(FW, 1, 10'h050);
    $display("t_video done");
  endtask
  task automatic t_sleep();
    send(CMD_SLEEP);
    a = 0;
    while (uut.o_power.pll !== 1'b0 && a < 4000) begin
      @(negedge clk);
      a++;
    end
    check("whole_frames", m.words.size(), 3 * FW);
    check("sleep_data", {31'h0, uut.o_serial_video_data_pos}, 32'h1);
    check("sleep_bus", {30'h0, uut.o_control_bus_enable, uut.o_power.pad_clk}, 32'h3);
    @(negedge clk);
    blank = 16'h0002;
    blank_load = 1'b1;
    clr = 1'b1;
    @(negedge clk);
    blank_load = 1'b0;
    clr = 1'b0;
    send(CMD_VIDEO);
    a = 0;
    while (uut.o_power.pll !== 1'b1 && a < 20) begin @(negedge clk); a++; end
    b = a;
    while (uut.o_power.analog !== 1'b1 && b < 20) begin @(negedge clk); b++; end
    c = b;
    while (uut.o_power.digital !== 1'b1 && c < 20) begin @(negedge clk); c++; end
    check("pll_to_analog", b - a, 1);
    check("analog_to_digital", c - b, 1);
    wait_words((PIX + 2) * (LINES + 2));
    chk_frame(0, 2, 10'h080);
    $display("t_sleep done");
  endtask
  task automatic t_pin_low();
    stby_n = 1'b0;
    repeat (8) @(negedge clk);
    check("pin_low_power", {27'h000_0000, uut.o_power}, 32'h0000_0001);
    check("pin_low_bus", {31'h0, uut.o_control_bus_enable}, 32'h0);
    check("pin_low_link", {29'h0, uut.o_qualifying_clock_pos, uut.o_serial_video_data_pos,
      uut.o_serial_video_data_neg}, 32'h2);
    check("link_pairs", m.bad, 0);
    $display("t_pin_low done");
  endtask
  always @(negedge clk) begin
    if (uut.o_pixel_take === 1'b1) begin
      takes++;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    {failures, tests_run, cyc, takes} = '0;
    {rst_n, stby_n, cmd_valid, blank_load, clr} = 5'h00;
    mode_cmd = CMD_SLEEP;
    blank = 16'h0001;
    pix = 10'h0c0;
    dark = 10'h040;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_standby();
    t_modes();
    t_video();
    t_sleep();
    t_pin_low();
    test_done();
  end
endmodule
`default_nettype wire
